//--- fieldbus_master_pkg.sv
// Constants, types and register map of the fieldbus master state control.
// Assumes one 40 MHz clock shared with the register port and the link logic.
// Summary of operation
// - After reset the fieldbus section stays inactive with every indicator dark.
// - Once bus parameters are loaded the master goes online and lights the run indicator.
// - While online the master answers probes at its own configured station address.
// - Valid configuration starts cyclic data exchange, shown on the exchange indicator.
// - Software hands over parameters and configuration; behaviour then follows the CPU state.
// - With the CPU stopped the master broadcasts Clear and blinks the exchange indicator.
// - With the CPU stopped, fail-safe slaves get output telegrams of length zero.
// - With the CPU stopped, other slaves get full telegrams with all data bytes zero.
// - With the CPU stopped, slave inputs are still copied into the CPU input area.
// - With the CPU running the master broadcasts Operate and holds the indicator lit.
// - With the CPU running every slave gets a telegram with the latest outputs each cycle.
// - With the CPU running, slave inputs are copied cyclically into the CPU input area.
// - All stations share one bit rate between 9.6 kbit/s and 12 Mbit/s set by the master.
package fieldbus_master_pkg;

    localparam int N_SLAVES  = 8;
    localparam int SLV_W     = 3;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int STA_W     = 7;
    localparam int LEN_W     = 3;
    localparam int RATE_W    = 4;

    localparam logic [LEN_W-1:0] OUT_BYTES = 3'h4;
    localparam logic [LEN_W-1:0] LEN_ZERO  = 3'h0;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATION  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_RATE     = 8'h08;
    localparam logic [ADDR_W-1:0] REG_SLAVES   = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h10;
    localparam logic [ADDR_W-1:0] REG_OUT_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] REG_IN_BASE  = 8'h80;
    localparam logic [ADDR_W-1:0] AREA_MASK    = 8'he0;
    localparam int               AREA_LSB     = 2;

    // Control register fields
    localparam int CTRL_PARAMS = 0;
    localparam int CTRL_CONFIG = 1;
    localparam int CTRL_RUN    = 2;

    // Slave register fields
    localparam int SLV_CNT_LSB = 0;
    localparam int SLV_CNT_W   = 4;
    localparam int FS_LSB      = 8;

    // Status register fields
    localparam int ST_ONLINE_BIT = 0;
    localparam int ST_XCHG_BIT   = 1;
    localparam int ST_MODE_BIT   = 2;
    localparam int ST_CYC_LSB    = 8;
    localparam int CYC_W         = 16;

    localparam logic [STA_W-1:0] STATION_RST = 7'h02;

    // Indicator blink timing
    localparam int CLK_HZ          = 40_000_000;
    localparam int BLINK_HALF_MS   = 500;
    localparam int BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_HALF_MS;
    localparam int BLINK_W         = 25;

    typedef enum logic [RATE_W-1:0] {
        RATE_9K6, RATE_19K2, RATE_45K45, RATE_93K75, RATE_187K5,
        RATE_500K, RATE_1M5, RATE_3M, RATE_6M, RATE_12M
    } bit_rate_t;

    typedef enum logic {GC_CLEAR, GC_OPERATE} gc_cmd_t;

    typedef struct packed {
        logic [SLV_W-1:0]  slave;
        logic [LEN_W-1:0]  len;
        logic [DATA_W-1:0] data;
    } telegram_t;

    typedef struct packed {
        logic              valid;
        logic [SLV_W-1:0]  slave;
        logic [DATA_W-1:0] data;
    } rx_word_t;

endpackage

//--- telegram_shaper.sv
// Output telegram length and data for one slave.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module telegram_shaper
    import fieldbus_master_pkg::*;
(
    input  wire logic              run_i,
    input  wire logic              failsafe_i,
    input  wire logic [DATA_W-1:0] out_word_i,
    output logic      [LEN_W-1:0]  len_o,
    output logic      [DATA_W-1:0] data_o
);

    always_comb
    begin
        len_o  = OUT_BYTES;
        data_o = out_word_i;
        if (!run_i)
        begin
            data_o = '0;
            if (failsafe_i)
            begin
                len_o = LEN_ZERO;
            end
        end
    end

endmodule
`default_nettype wire

//--- led_blinker.sv
// Free-running square wave for a blinking indicator.
// Restarts dark whenever disabled.
`timescale 1ns/1ps
`default_nettype none
module led_blinker
    import fieldbus_master_pkg::*;
#(
    parameter int HALF_CYCLES = BLINK_HALF_CYC
)
(
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic enable_i,
    output logic      blink_o
);

    logic [BLINK_W-1:0] count;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count   <= '0;
            blink_o <= 1'b0;
        end
        else if (!enable_i)
        begin
            count   <= '0;
            blink_o <= 1'b0;
        end
        else if (count == BLINK_W'(HALF_CYCLES - 1))
        begin
            count   <= '0;
            blink_o <= ~blink_o;
        end
        else
        begin
            count <= count + 1'b1;
        end
    end

endmodule
`default_nettype wire

//--- fieldbus_master_ctrl.sv
// Fieldbus master state control: register port, bus cycle sequencer,
// output shaping per slave and input area capture.
// Assumes link logic on the same clock handles framing and bit timing.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_ctrl
    import fieldbus_master_pkg::*;
#(
    parameter int BLINK_HALF = BLINK_HALF_CYC
)
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    output logic                   gc_valid_o,
    output gc_cmd_t                gc_cmd_o,
    input  wire logic              gc_done_i,
    output logic                   tg_valid_o,
    output telegram_t              tg_o,
    input  wire logic              tg_done_i,
    input  wire rx_word_t          rx_i,
    input  wire logic              probe_valid_i,
    input  wire logic [STA_W-1:0]  probe_addr_i,
    output logic                   probe_hit_o,
    output logic                   bus_online_o,
    output bit_rate_t              bit_rate_o,
    output logic                   led_run_o,
    output logic                   data_exchange_indicator_o
);

    typedef enum logic [2:0] {ST_OFF, ST_ONLINE, ST_GLOBAL, ST_SLAVE} state_t;

    state_t                state;
    state_t                next_state;
    logic                  params_loaded;
    logic                  config_valid;
    logic                  cpu_run;
    logic                  cycle_run;
    logic [STA_W-1:0]      station_addr;
    bit_rate_t             rate_sel;
    logic [SLV_CNT_W-1:0]  slave_count;
    logic [N_SLAVES-1:0]   failsafe_mask;
    logic [SLV_W-1:0]      slave_idx;
    logic [SLV_W-1:0]      next_idx;
    logic [CYC_W-1:0]      cycle_count;
    logic [DATA_W-1:0]     out_area [N_SLAVES];
    logic [DATA_W-1:0]     in_area  [N_SLAVES];
    logic                  exchanging;
    logic                  last_slave;
    logic                  next_run;
    logic [LEN_W-1:0]      shaped_len;
    logic [DATA_W-1:0]     shaped_data;
    logic                  blink;
    logic                  area_hit_out;
    logic                  area_hit_in;
    logic [SLV_W-1:0]      area_idx;

    assign exchanging   = (state == ST_GLOBAL) || (state == ST_SLAVE);
    assign last_slave   = ({1'b0, slave_idx} == slave_count - 1'b1);
    assign area_idx     = reg_addr_i[AREA_LSB +: SLV_W];
    assign area_hit_out = (reg_addr_i & AREA_MASK) == REG_OUT_BASE;
    assign area_hit_in  = (reg_addr_i & AREA_MASK) == REG_IN_BASE;
    // Telegrams keep the mode latched when their bus cycle opened
    assign next_run     = cycle_run;

    // Register writes from software
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            params_loaded <= 1'b0;
            config_valid  <= 1'b0;
            cpu_run       <= 1'b0;
            station_addr  <= STATION_RST;
            rate_sel      <= RATE_9K6;
            slave_count   <= '0;
            failsafe_mask <= '0;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                REG_CTRL:
                begin
                    params_loaded <= reg_wdata_i[CTRL_PARAMS];
                    config_valid  <= reg_wdata_i[CTRL_CONFIG];
                    cpu_run       <= reg_wdata_i[CTRL_RUN];
                end
                REG_STATION: station_addr <= reg_wdata_i[STA_W-1:0];
                REG_RATE:
                begin
                    if (reg_wdata_i[RATE_W-1:0] <= RATE_12M)
                    begin
                        rate_sel <= bit_rate_t'(reg_wdata_i[RATE_W-1:0]);
                    end
                end
                REG_SLAVES:
                begin
                    slave_count   <= reg_wdata_i[SLV_CNT_LSB +: SLV_CNT_W];
                    failsafe_mask <= reg_wdata_i[FS_LSB +: N_SLAVES];
                end
                default: ;
            endcase
        end
    end

    // CPU output area
    always_ff @(posedge clk_sys_i)
    begin
        if (reg_wr_i && area_hit_out)
        begin
            out_area[area_idx] <= reg_wdata_i;
        end
    end

    // Slave inputs land in the CPU input area in either CPU state
    always_ff @(posedge clk_sys_i)
    begin
        if (exchanging && rx_i.valid)
        begin
            in_area[rx_i.slave] <= rx_i.data;
        end
    end

    // Register reads, answered one cycle later
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o <= '0;
        end
        else if (reg_rd_i)
        begin
            reg_rdata_o <= '0;
            if (area_hit_out)
            begin
                reg_rdata_o <= out_area[area_idx];
            end
            else if (area_hit_in)
            begin
                reg_rdata_o <= in_area[area_idx];
            end
            else
            begin
                case (reg_addr_i)
                    REG_CTRL:
                    begin
                        reg_rdata_o[CTRL_PARAMS] <= params_loaded;
                        reg_rdata_o[CTRL_CONFIG] <= config_valid;
                        reg_rdata_o[CTRL_RUN]    <= cpu_run;
                    end
                    REG_STATION: reg_rdata_o[STA_W-1:0] <= station_addr;
                    REG_RATE:    reg_rdata_o[RATE_W-1:0] <= rate_sel;
                    REG_SLAVES:
                    begin
                        reg_rdata_o[SLV_CNT_LSB +: SLV_CNT_W] <= slave_count;
                        reg_rdata_o[FS_LSB +: N_SLAVES]       <= failsafe_mask;
                    end
                    REG_STATUS:
                    begin
                        reg_rdata_o[ST_ONLINE_BIT]       <= (state != ST_OFF);
                        reg_rdata_o[ST_XCHG_BIT]         <= exchanging;
                        reg_rdata_o[ST_MODE_BIT]         <= cycle_run;
                        reg_rdata_o[ST_CYC_LSB +: CYC_W] <= cycle_count;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Bus cycle sequencer
    always_comb
    begin
        next_state = state;
        next_idx   = slave_idx;
        case (state)
            ST_OFF:
            begin
                if (params_loaded)
                begin
                    next_state = ST_ONLINE;
                end
            end
            ST_ONLINE:
            begin
                if (!params_loaded)
                begin
                    next_state = ST_OFF;
                end
                else if (config_valid && (slave_count != '0))
                begin
                    next_state = ST_GLOBAL;
                end
            end
            ST_GLOBAL:
            begin
                if (gc_valid_o && gc_done_i)
                begin
                    next_state = ST_SLAVE;
                    next_idx   = '0;
                end
            end
            ST_SLAVE:
            begin
                if (tg_valid_o && tg_done_i)
                begin
                    if (!params_loaded)
                    begin
                        next_state = ST_OFF;
                    end
                    else if (!config_valid || (slave_count == '0))
                    begin
                        next_state = ST_ONLINE;
                    end
                    else if (last_slave)
                    begin
                        next_state = ST_GLOBAL;
                    end
                    else
                    begin
                        next_idx = slave_idx + 1'b1;
                    end
                end
            end
            default: next_state = ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state     <= ST_OFF;
            slave_idx <= '0;
        end
        else
        begin
            state     <= next_state;
            slave_idx <= next_idx;
        end
    end

    // CPU state is sampled only when a new bus cycle opens
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cycle_run   <= 1'b0;
            cycle_count <= '0;
        end
        else if ((next_state == ST_GLOBAL) && (state != ST_GLOBAL))
        begin
            cycle_run   <= cpu_run;
            cycle_count <= cycle_count + 1'b1;
        end
    end

    telegram_shaper u_shaper (
        .run_i      (next_run),
        .failsafe_i (failsafe_mask[next_idx]),
        .out_word_i (out_area[next_idx]),
        .len_o      (shaped_len),
        .data_o     (shaped_data)
    );

    // Broadcast and telegram requests to the link
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gc_valid_o <= 1'b0;
            gc_cmd_o   <= GC_CLEAR;
            tg_valid_o <= 1'b0;
            tg_o       <= '0;
        end
        else
        begin
            gc_valid_o <= (next_state == ST_GLOBAL);
            if ((next_state == ST_GLOBAL) && (state != ST_GLOBAL))
            begin
                gc_cmd_o <= cpu_run ? GC_OPERATE : GC_CLEAR;
            end
            tg_valid_o <= (next_state == ST_SLAVE);
            if ((next_state == ST_SLAVE) && !(tg_valid_o && !tg_done_i))
            begin
                tg_o.slave <= next_idx;
                tg_o.len   <= shaped_len;
                tg_o.data  <= shaped_data;
            end
        end
    end

    led_blinker #(
        .HALF_CYCLES (BLINK_HALF)
    ) u_blink (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .enable_i  (exchanging && !cycle_run),
        .blink_o   (blink)
    );

    // Indicators, station address probe and line settings
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            led_run_o                 <= 1'b0;
            data_exchange_indicator_o <= 1'b0;
            probe_hit_o               <= 1'b0;
            bus_online_o              <= 1'b0;
            bit_rate_o                <= RATE_9K6;
        end
        else
        begin
            led_run_o    <= (state != ST_OFF);
            bus_online_o <= (state != ST_OFF);
            bit_rate_o   <= rate_sel;
            data_exchange_indicator_o <= exchanging && (cycle_run || blink);
            probe_hit_o  <= (state != ST_OFF) && probe_valid_i
                            && (probe_addr_i == station_addr);
        end
    end

    a_dark_offline: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state == ST_OFF) |=> !led_run_o && !data_exchange_indicator_o)
        else $error("indicator lit while fieldbus inactive");

    a_online_run_led: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state == ST_OFF) && params_loaded |=> ##1 led_run_o)
        else $error("run indicator not lit after going online");

    a_probe_answer: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state != ST_OFF) && probe_valid_i && (probe_addr_i == station_addr)
        |=> probe_hit_o)
        else $error("own station address not answered");

    a_exchange_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state == ST_ONLINE) && params_loaded && config_valid && (slave_count != '0)
        |=> gc_valid_o)
        else $error("valid configuration did not start exchange");

    a_clear_when_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        gc_valid_o && !cycle_run |-> gc_cmd_o == GC_CLEAR)
        else $error("clear not sent while stopped");

    a_operate_when_run: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        gc_valid_o && cycle_run |-> gc_cmd_o == GC_OPERATE)
        else $error("operate not sent while running");

    a_led_steady_run: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        exchanging && cycle_run && $stable(cycle_run) |=> data_exchange_indicator_o)
        else $error("exchange indicator not steady while running");

    a_failsafe_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tg_valid_o && !cycle_run && failsafe_mask[tg_o.slave] && $stable(failsafe_mask)
        |-> tg_o.len == LEN_ZERO)
        else $error("fail-safe slave got outputs while stopped");

    a_stop_zero_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tg_valid_o && !cycle_run |-> tg_o.data == '0)
        else $error("output data not forced to zero while stopped");

    a_run_full_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tg_valid_o && cycle_run |-> tg_o.len == OUT_BYTES)
        else $error("short telegram while running");

    a_mode_per_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state == ST_SLAVE) && (next_state == ST_SLAVE) |=> $stable(cycle_run))
        else $error("mode changed inside a bus cycle");

    c_stop_cycle: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        gc_valid_o && gc_done_i && (gc_cmd_o == GC_CLEAR));

    c_run_cycle: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        gc_valid_o && gc_done_i && (gc_cmd_o == GC_OPERATE));

    c_failsafe_tg: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tg_valid_o && tg_done_i && (tg_o.len == LEN_ZERO));

    c_input_copy: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        exchanging && rx_i.valid);

endmodule
`default_nettype wire

//--- fieldbus_slave_model.sv
// Behavioural slave stations on the far side of the link interface.
// Assumes the controller's clock; answers each request delay_i + 1 cycles after it is first seen.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_slave_model
    import fieldbus_master_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic [3:0] delay_i,
    input  wire logic       gc_valid_i,
    input  wire logic       tg_valid_i,
    input  wire telegram_t  tg_i,
    output logic            gc_done_o,
    output logic            tg_done_o,
    output rx_word_t        rx_o
);
    logic [3:0] wait_cnt;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_cnt  <= 4'h0;
            gc_done_o <= 1'b0;
            tg_done_o <= 1'b0;
            rx_o      <= '0;
        end
        else
        begin
            gc_done_o  <= 1'b0;
            tg_done_o  <= 1'b0;
            rx_o.valid <= 1'b0;
            // Stale word is not held once the reply is over
            rx_o.data  <= ~rx_o.data;
            if (gc_done_o || tg_done_o || !(gc_valid_i || tg_valid_i))
                wait_cnt <= 4'h0;
            else if (wait_cnt != delay_i)
                wait_cnt <= wait_cnt + 4'h1;
            else if (gc_valid_i)
                gc_done_o <= 1'b1;
            else
            begin
                // Slave echoes its outputs inverted as input data
                tg_done_o  <= 1'b1;
                rx_o.valid <= 1'b1;
                rx_o.slave <= tg_i.slave;
                rx_o.data  <= ~tg_i.data;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the fieldbus master state control.
// Assumes the slave model answers the link side on the same clock.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import fieldbus_master_pkg::*;
;
    logic              clk_sys_i, rst_n_i, reg_wr, reg_rd, probe_valid;
    logic              gc_done, tg_done, gc_valid, tg_valid, probe_hit, online, led_run, dx_led;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
    logic [STA_W-1:0]  probe_addr;
    logic [3:0]        delay;
    gc_cmd_t           gc_cmd, seen_cmd;
    telegram_t         tg;
    rx_word_t          rx;
    bit_rate_t         rate;
    int                fails, compares;
    int                n_gc = 0;
    logic [LEN_W-1:0]  seen_len[N_SLAVES];
    logic [DATA_W-1:0] seen_data[N_SLAVES];
    logic [DATA_W-1:0] out_w[3] = '{32'h1234_5678, 32'h9abc_def0, 32'h0f0f_a5a5};

    fieldbus_master_ctrl #(.BLINK_HALF(4)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .gc_valid_o(gc_valid), .gc_cmd_o(gc_cmd), .gc_done_i(gc_done),
        .tg_valid_o(tg_valid), .tg_o(tg), .tg_done_i(tg_done), .rx_i(rx),
        .probe_valid_i(probe_valid), .probe_addr_i(probe_addr), .probe_hit_o(probe_hit),
        .bus_online_o(online), .bit_rate_o(rate), .led_run_o(led_run),
        .data_exchange_indicator_o(dx_led));
    fieldbus_slave_model i_slaves (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .delay_i(delay),
        .gc_valid_i(gc_valid), .tg_valid_i(tg_valid), .tg_i(tg), .gc_done_o(gc_done),
        .tg_done_o(tg_done), .rx_o(rx));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i)
    begin
        if (tg_valid && tg_done)
        begin
            seen_len[tg.slave]  <= tg.len;
            seen_data[tg.slave] <= tg.data;
        end
        if (gc_valid && gc_done)
        begin
            seen_cmd <= gc_cmd;
            n_gc     <= n_gc + 1;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic probe(input logic [6:0] a, input logic hit);
        @(posedge clk_sys_i);
        probe_valid <= 1'b1;
        probe_addr  <= a;
        @(posedge clk_sys_i);
        probe_valid <= 1'b0;
        #1 check("probe_hit", {31'h0, probe_hit}, {31'h0, hit});
    endtask

    task automatic wait_gc(input int n);
        int target;
        target = n_gc + n;
        for (int k = 0; k < 3000 && n_gc < target; k++)
            @(posedge clk_sys_i) #1;
        if (n_gc < target)
        begin
            fails++;
            stop_test();
        end
    endtask

    task automatic t_reset();
        check("idle", {27'h0, online, led_run, dx_led, gc_valid, tg_valid}, 32'h0);
        reg_read(REG_STATION);
        check("station", rd_val, 32'h2);
        reg_read(8'h20);
        check("unmapped", rd_val, 32'h0);
    endtask

    task automatic t_online();
        reg_write(REG_RATE, 32'h9);
        reg_write(REG_RATE, 32'ha);
        reg_read(REG_RATE);
        check("rate", {rd_val[27:0], rate}, 32'h99);
        reg_write(REG_STATION, 32'h5);
        reg_write(REG_CTRL, 32'h1);
        repeat (2) @(posedge clk_sys_i);
        #1 check("run_led", {29'h0, online, led_run, gc_valid}, 32'h6);
        probe(7'h05, 1'b1);
        probe(7'h06, 1'b0);
    endtask

    task automatic t_stop();
        int tog;
        logic prev;
        for (int i = 0; i < 3; i++)
            reg_write(REG_OUT_BASE + 8'(4 * i), out_w[i]);
        reg_write(REG_SLAVES, 32'h0000_0203);
        reg_write(REG_CTRL, 32'h3);
        wait_gc(3);
        check("cmd_stop", {31'h0, seen_cmd}, {31'h0, GC_CLEAR});
        for (int i = 0; i < 3; i++)
        begin
            check("len_stop", {29'h0, seen_len[i]}, (i == 1) ? 32'h0 : 32'h4);
            check("data_stop", seen_data[i], 32'h0);
            reg_read(REG_IN_BASE + 8'(4 * i));
            check("in_stop", rd_val, 32'hffff_ffff);
        end
        reg_read(REG_STATUS);
        check("status", {29'h0, rd_val[2:0]}, 32'h3);
        tog = 0;
        prev = dx_led;
        repeat (16) @(posedge clk_sys_i)
        begin
            #1 tog += (dx_led !== prev);
            prev = dx_led;
        end
        check("blink", {31'h0, tog >= 3}, 32'h1);
    endtask

    task automatic t_run();
        int dark;
        delay <= 4'h5;
        reg_write(REG_CTRL, 32'h7);
        wait_gc(3);
        check("cmd_run", {31'h0, seen_cmd}, {31'h0, GC_OPERATE});
        for (int i = 0; i < 3; i++)
        begin
            check("len_run", {29'h0, seen_len[i]}, 32'h4);
            check("data_run", seen_data[i], out_w[i]);
            reg_read(REG_IN_BASE + 8'(4 * i));
            check("in_run", rd_val, ~out_w[i]);
        end
        dark = 0;
        repeat (16) @(posedge clk_sys_i) #1 dark += (dx_led !== 1'b1);
        check("steady", dark, 32'h0);
        reg_write(REG_OUT_BASE, 32'hcafe_0001);
        wait_gc(3);
        check("latest", seen_data[0], 32'hcafe_0001);
        reg_write(REG_CTRL, 32'h0);
        repeat (40) @(posedge clk_sys_i);
        #1 check("offline", {27'h0, online, led_run, dx_led, gc_valid, tg_valid}, 32'h0);
    endtask

    initial
    begin
        rst_n_i = 1'b0;
        {reg_wr, reg_rd, probe_valid} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        probe_addr = 7'h00;
        delay = 4'h1;
        {fails, compares} = 0;
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_online();
        t_stop();
        t_run();
        stop_test();
    end
endmodule
`default_nettype wire
